// ### memmap_defines.svh
// Address map, register layout and reset constants for the memory map controller
`ifndef MEMMAP_DEFINES_SVH
`define MEMMAP_DEFINES_SVH
`define REMAP_WIN_BASE    32'h0000_0000
`define REMAP_WIN_BITS    16
`define VECTOR_TOP        32'h0000_0020
`define FLASH_BASE        32'h0008_0000
`define FLASH_BITS        16
`define FLASH_USER_LIMIT  32'h0000_F800
`define SRAM_BASE         32'h0004_0000
`define SRAM_AW           10
`define MMR_BASE          32'hFFFF_F000
`define MMR_REGION_BITS   12
`define MMR_REMAP_ADDR    32'hFFFF_0220
`define MMR_FMODE_ADDR    32'hFFFF_0E04
`define MMR_TOP_BASE      32'hFFFF_0000
`define MMR_TOP_BITS      16
`define REMAP_BIT         0
`define FMODE_ABORT_BIT   1
`define FMODE_EWEN_BIT    3
`define FMODE_CIEN_BIT    4
`define FMODE_LOCK_HI     6
`define FMODE_LOCK_LO     5
`define FMODE_LOCK_PAT    2'h2
`define FMODE_WMASK       16'h007A
`define FMODE_RESET       16'h0000
`define REMAP_RESET       8'h00
`define KERNEL_CYCLES     8'h10
`define RESET_VECTOR      32'h0000_0000
`endif

// ### memmap_pkg.sv
// Types shared by the memory map controller
`default_nettype none
package memmap_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} acc_size_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    acc_size_t   size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cpu_req_t;
  typedef struct packed {
    logic        ok;
    logic        abort;
    logic [31:0] rdata;
  } cpu_rsp_t;
endpackage
`default_nettype wire

// ### sram_store.sv
// Word-wide SRAM with per-byte write enables
`timescale 1ns/1ns
`default_nettype none
module sram_store #(
  parameter int AW = 10
) (
  input  wire logic          mclk,   // System clock
  input  wire logic          en,     // Access enable
  input  wire logic [3:0]    be,     // Byte write enables
  input  wire logic [AW-1:0] addr,   // Word address
  input  wire logic [31:0]   wdata,  // Write data, lane aligned
  output logic      [31:0]   rdata   // Read data, registered
);
  logic [31:0] mem [0:(1<<AW)-1];

  // One-cycle read; full-width array so fetches run without stalls
  always_ff @(posedge mclk) begin
    if (en) begin
      for (int i = 0; i < 4; i++) begin
        if (be[i]) begin
          mem[addr][8*i +: 8] <= wdata[8*i +: 8];
        end
      end
      rdata <= mem[addr];
    end
  end
endmodule // sram_store
`default_nettype wire

// ### memmap_ctrl.sv
// Address decoder, remap control, boot sequencing and flash mode register
// Notes on behaviour
// - Accesses outside every mapped region raise a data abort.
// - Lowest 64 kB is a window onto flash or SRAM.
// - Top 64 kB decodes as the peripheral register area.
// - Flash: 62 kB user space, top 2 kB reserved for kernel.
// - Little endian: low byte at lowest address.
// - SRAM is 1024 x 32 words at 0x40000, for data and code.
// - SRAM takes byte, half and word accesses; full-rate 32-bit reads.
// - Exception vectors sit from zero up to 0x20.
// - Flash is mapped at zero after every reset.
// - Remap bit 0 set maps SRAM at zero; cleared maps flash.
// - After reset the kernel runs first, then branches to address zero.
// - Kernel flash area is hidden from user code.
// - Flash mode bits 6:5 written as 1,0 complete the security lock.
// - Flash mode bit 4 enables the command-complete interrupt.
// - Erase and write commands allowed only while bit 3 set.
// - Flash mode bit 1 enables the controller abort capability.
// - Kernel samples the test reset input to choose serial boot-load.
// - General-purpose pins leave reset as inputs.
// - Pins 0 to 3 select SPI slave select, clock, data out, data in.
// - JTAG data output disabled at power-on.
// - External reset input is active low.
`timescale 1ns/1ns
`default_nettype none
`include "memmap_defines.svh"
module memmap_ctrl
  import memmap_pkg::*;
#(
  parameter int SRAM_AW = `SRAM_AW,
  parameter int NGPIO   = 6
) (
  input  wire logic             mclk,          // 10 MHz system clock
  input  wire logic             rst,           // Power-on reset, active high
  input  wire logic             ext_reset_n,   // External reset pin, active low
  input  wire logic             test_reset_n,  // JTAG test reset, sampled at boot
  input  wire cpu_req_t         req,           // Core access request
  output cpu_rsp_t              rsp,           // Core access response
  output logic                  kernel_mode,   // Core running hidden kernel
  output logic                  boot_jump,     // Pulse: branch to reset vector
  output logic [31:0]           boot_vector,   // Branch target
  output logic                  serial_boot,   // Serial boot-load chosen
  output logic                  flash_en,      // Flash array strobe
  output logic                  flash_we,      // Flash array write
  output logic [`FLASH_BITS-1:0] flash_addr,   // Flash byte address
  output logic [31:0]           flash_wdata,   // Flash write data
  input  wire logic [31:0]      flash_rdata,   // Flash read data
  input  wire logic             fcmd_valid,    // Flash erase/write command issued
  output logic                  fcmd_accept,   // Command passed to the array engine
  input  wire logic             fcmd_done,     // Flash command finished
  output logic                  flash_irq,     // Command-complete interrupt
  output logic                  flash_abort_en,// Abort capability enabled
  output logic                  flash_locked,  // Security lock step done
  output logic [NGPIO-1:0]      gpio_oe,       // Pin output enables
  input  wire logic [NGPIO-1:0] gpio_in,       // Pin inputs
  input  wire logic [NGPIO-1:0] gpio_out_reg,  // Pin output values from port logic
  input  wire logic [NGPIO-1:0] gpio_oe_reg,   // Pin directions from port logic
  input  wire logic             spi_sel,       // Route pins 0..3 to SPI
  input  wire logic             spi_miso,      // SPI slave data out
  output logic [NGPIO-1:0]      gpio_out,      // Pin output values
  output logic                  spi_ss_n,      // SPI slave select in
  output logic                  spi_sclk,      // SPI clock in
  output logic                  spi_mosi,      // SPI slave data in
  output logic                  tdo_oe         // JTAG data output enable
);
  typedef enum logic [1:0] {BOOT_KERNEL, BOOT_JUMP, BOOT_USER} boot_t;

  logic        any_rst;
  logic [7:0]  remap_q;
  logic [15:0] fmode_q;
  boot_t       boot_q;
  logic [7:0]  kcnt_q;
  logic        serial_q;
  logic        irq_q;
  logic        tdo_en_q;
  logic [31:0] a;
  logic        hit_win, hit_sram, hit_flash, hit_mmr, hit_remap, hit_fmode;
  logic        win_sram, kernel_hidden, sram_sel, size_ok;
  logic [3:0]  be;
  logic [31:0] lane_wdata, sram_rdata;
  logic [1:0]  rsel_q;
  logic [31:0] mmr_rdata_q;
  logic        pend_q, abort_q;

  // External pin folds into the same asynchronous reset
  assign any_rst = rst | ~ext_reset_n;
  assign a = req.addr;

  // Region decode
  assign hit_win   = (a >> `REMAP_WIN_BITS) == (`REMAP_WIN_BASE >> `REMAP_WIN_BITS);
  assign hit_sram  = (a >> (SRAM_AW + 2)) == (`SRAM_BASE >> (SRAM_AW + 2));
  assign hit_flash = (a >> `FLASH_BITS) == (`FLASH_BASE >> `FLASH_BITS);
  assign hit_mmr   = ((a >> `MMR_REGION_BITS) == (`MMR_BASE >> `MMR_REGION_BITS))
                   | ((a >> `MMR_TOP_BITS) == (`MMR_TOP_BASE >> `MMR_TOP_BITS));
  assign hit_remap = {a[31:2], 2'b00} == `MMR_REMAP_ADDR;
  assign hit_fmode = {a[31:2], 2'b00} == `MMR_FMODE_ADDR;
  assign win_sram  = remap_q[`REMAP_BIT];
  assign sram_sel  = hit_sram | (hit_win & win_sram &
                     (a[`REMAP_WIN_BITS-1:0] < 16'((1 << (SRAM_AW + 2)) - 1) + 16'h0001));
  // Kernel area hidden unless the core is still in the boot kernel
  assign kernel_hidden = ~kernel_mode & (hit_flash | (hit_win & ~win_sram)) &
                         ({16'h0000, a[`FLASH_BITS-1:0]} >= `FLASH_USER_LIMIT);
  // Size and alignment check
  always_comb begin
    unique case (req.size)
      SZ_BYTE: size_ok = 1'b1;
      SZ_HALF: size_ok = ~a[0];
      SZ_WORD: size_ok = a[1:0] == 2'b00;
      default: size_ok = 1'b0;
    endcase
  end

  // Byte lanes: lowest address is least significant lane
  always_comb begin
    be = 4'h0;
    lane_wdata = 32'h0000_0000;
    unique case (req.size)
      SZ_BYTE: begin
        be[a[1:0]] = 1'b1;
        lane_wdata = {4{req.wdata[7:0]}};
      end
      SZ_HALF: begin
        be = a[1] ? 4'hC : 4'h3;
        lane_wdata = {2{req.wdata[15:0]}};
      end
      default: begin
        be = 4'hF;
        lane_wdata = req.wdata;
      end
    endcase
  end

  sram_store #(.AW(SRAM_AW)) u_sram (
    .mclk  (mclk),
    .en    (req.valid & sram_sel & size_ok),
    .be    (req.write ? be : 4'h0),
    .addr  (a[SRAM_AW+1:2]),
    .wdata (lane_wdata),
    .rdata (sram_rdata)
  );

  // Flash array port; flash reads are word wide
  assign flash_en    = req.valid & size_ok & ~kernel_hidden & (hit_flash | (hit_win & ~win_sram));
  assign flash_we    = flash_en & req.write & fmode_q[`FMODE_EWEN_BIT];
  assign flash_addr  = a[`FLASH_BITS-1:0];
  assign flash_wdata = lane_wdata;

  // Boot sequencing: hidden kernel runs a fixed count then jumps to zero
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      boot_q <= BOOT_KERNEL;
      kcnt_q <= 8'h00;
    end else begin
      unique case (boot_q)
        BOOT_KERNEL: begin
          kcnt_q <= kcnt_q + 8'h01;
          if (kcnt_q == `KERNEL_CYCLES - 8'h01) begin
            boot_q <= BOOT_JUMP;
          end
        end
        BOOT_JUMP: boot_q <= BOOT_USER;
        BOOT_USER: boot_q <= BOOT_USER;
        default:   boot_q <= BOOT_KERNEL;
      endcase
    end
  end
  assign kernel_mode = boot_q != BOOT_USER;
  assign boot_jump   = boot_q == BOOT_JUMP;
  assign boot_vector = `RESET_VECTOR;

  // Test reset level caught by the kernel after release, not at reset
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      serial_q <= 1'b0;
    end else if (boot_q == BOOT_KERNEL && kcnt_q == 8'h00) begin
      serial_q <= test_reset_n;
    end
  end
  assign serial_boot = serial_q;

  // Remap control register
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      remap_q <= `REMAP_RESET;
    end else if (req.valid && req.write && hit_remap) begin
      remap_q <= {7'h00, req.wdata[`REMAP_BIT]};
    end
  end

  // Flash mode register; reserved bits held at zero whatever is written
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      fmode_q <= `FMODE_RESET;
    end else if (req.valid && req.write && hit_fmode && size_ok) begin
      fmode_q <= req.wdata[15:0] & `FMODE_WMASK;
    end
  end
  assign flash_abort_en = fmode_q[`FMODE_ABORT_BIT];
  assign flash_locked   = fmode_q[`FMODE_LOCK_HI:`FMODE_LOCK_LO] == `FMODE_LOCK_PAT;
  // Commands while erase/write disabled never reach the engine
  assign fcmd_accept    = fcmd_valid & fmode_q[`FMODE_EWEN_BIT];

  // Completion interrupt only while enabled
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= fcmd_done & fmode_q[`FMODE_CIEN_BIT];
    end
  end
  assign flash_irq = irq_q;

  // Response path: registered one cycle after request
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      pend_q      <= 1'b0;
      abort_q     <= 1'b0;
      rsel_q      <= 2'h0;
      mmr_rdata_q <= 32'h0000_0000;
    end else begin
      pend_q  <= req.valid;
      abort_q <= req.valid & (~size_ok | kernel_hidden |
                 ~(sram_sel | hit_flash | (hit_win & ~win_sram) | hit_mmr));
      rsel_q  <= sram_sel ? 2'h1 : (hit_mmr ? 2'h2 : 2'h0);
      mmr_rdata_q <= hit_remap ? {24'h000000, remap_q} :
                     (hit_fmode ? {16'h0000, fmode_q} : 32'h0000_0000);
    end
  end
  assign rsp.abort = pend_q & abort_q;
  assign rsp.ok    = pend_q & ~abort_q;
  assign rsp.rdata = abort_q ? 32'h0000_0000 :
                     (rsel_q == 2'h1 ? sram_rdata : (rsel_q == 2'h2 ? mmr_rdata_q : flash_rdata));

  // JTAG data output off until the kernel has finished
  always_ff @(posedge mclk or posedge any_rst) begin
    if (any_rst) begin
      tdo_en_q <= 1'b0;
    end else if (boot_q == BOOT_JUMP) begin
      tdo_en_q <= 1'b1;
    end
  end
  assign tdo_oe = tdo_en_q;

  // Pin muxing; all pins held as inputs while the kernel runs, whatever the port logic sets
  always_comb begin
    gpio_out = gpio_out_reg;
    gpio_oe  = kernel_mode ? '0 : gpio_oe_reg;
    if (spi_sel) begin
      gpio_oe[3:0]  = kernel_mode ? 4'h0 : 4'h4;
      gpio_out[2]   = spi_miso;
    end
  end
  assign spi_ss_n = spi_sel ? gpio_in[0] : 1'b1;
  assign spi_sclk = spi_sel & gpio_in[1];
  assign spi_mosi = spi_sel & gpio_in[3];
endmodule // memmap_ctrl
`default_nettype wire

// ### memmap_checker.sv
// Port-level assertions for the memory map controller
`timescale 1ns/1ns
`default_nettype none
module memmap_checker
  import memmap_pkg::*;
#(parameter int NGPIO = 6) (
  input wire logic             mclk,           // Clock
  input wire logic             rst,            // Reset
  input wire logic             ext_reset_n,    // Pin reset
  input wire cpu_req_t         req,            // Request
  input wire cpu_rsp_t         rsp,            // Answer
  input wire logic             kernel_mode,    // Kernel on
  input wire logic             fcmd_valid,     // Command in
  input wire logic             fcmd_accept,    // Command out
  input wire logic             fcmd_done,      // Command end
  input wire logic             flash_irq,      // Interrupt
  input wire logic             flash_abort_en, // Abort enable
  input wire logic [NGPIO-1:0] gpio_oe,        // Pin enables
  input wire logic             tdo_oe          // Debug out enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || !ext_reset_n);
  // Address classes; the kernel area is the top 2 kB of flash
  wire hole = req.valid && req.addr[31:20] == 12'h200;
  wire hide = req.valid && !kernel_mode && req.addr[31:11] == 21'h0011F;
  wire fmw  = req.valid && req.write && req.addr == 32'hFFFF_0E04;
  a_unmapped_abort: assert property (hole |=> rsp.abort && !rsp.ok) else $error("no abort on hole");
  a_kernel_hidden: assert property (hide |=> rsp.abort) else $error("kernel area reached");
  a_one_answer: assert property (req.valid |=> rsp.ok != rsp.abort) else $error("bad answer");
  a_quiet_idle: assert property (!req.valid |=> !rsp.ok && !rsp.abort) else $error("stray answer");
  a_misaligned_abort: assert property (req.valid && req.size == SZ_WORD && req.addr[1:0] != 2'h0 |=> rsp.abort)
    else $error("misaligned taken");
  a_cmd_gate: assert property (fcmd_accept |-> fcmd_valid) else $error("command unasked");
  a_irq_cause: assert property (flash_irq |-> $past(fcmd_done)) else $error("irq without end");
  a_abort_hold: assert property (!fmw |=> $stable(flash_abort_en)) else $error("abort enable moved");
  a_pins_input: assert property (kernel_mode |-> gpio_oe == '0 && !tdo_oe) else $error("pin driven");
  a_kernel_leave: assert property (kernel_mode |-> ##[1:20] !kernel_mode) else $error("kernel stuck");
  c_abort: cover property (rsp.abort);
  c_irq: cover property (flash_irq);
  c_accept: cover property (fcmd_accept);
endmodule // memmap_checker
bind memmap_ctrl memmap_checker #(.NGPIO(NGPIO)) chk_i (.mclk, .rst, .ext_reset_n, .req, .rsp, .kernel_mode,
  .fcmd_valid, .fcmd_accept, .fcmd_done, .flash_irq, .flash_abort_en, .gpio_oe, .tdo_oe);
`default_nettype wire

// ### flash_model.sv
// Flash array behind the controller's array port
`timescale 1ns/1ns
`default_nettype none
module flash_model (
  input wire logic        mclk,  // Clock
  input wire logic        en,    // Strobe
  input wire logic        we,    // Write
  input wire logic [15:0] addr,  // Byte address
  input wire logic [31:0] wdata, // Write data
  output logic     [31:0] rdata  // Read data
);
  logic [31:0] mem_q [0:16383];
  logic        rd_q = 1'b0;
  logic [31:0] last_q = 32'h0;
  // Known pattern per word so reads can be predicted; word 0 stands in for the reset handler
  initial for (int i = 0; i < 16384; i++) mem_q[i] = {16'hF1A5, i[15:0]};
  // Whole 64 kB array; writes land only when the controller strobes them
  always @(posedge mclk) begin
    if (en && we) mem_q[addr[15:2]] <= wdata;
    if (en && !we) last_q <= mem_q[addr[15:2]];
    rd_q <= en && !we;
  end
  // Read data stands one cycle; otherwise the port shows junk
  assign rdata = rd_q ? last_q : ~last_q;
endmodule // flash_model
`default_nettype wire

// ### test_memory_map_remap_control.sv
// Self-checking bench for the memory map controller
`timescale 1ns/1ns
`default_nettype none
`include "memmap_defines.svh"
module test_memory_map_remap_control;
  import memmap_pkg::*;
  logic        mclk = 0, rst = 1, ext_reset_n = 1, test_reset_n = 0;
  logic        fcmd_valid = 0, fcmd_done = 0, spi_sel = 0, spi_miso = 0;
  logic [5:0]  gpio_in = 6'h3F;
  logic [5:0]  port_out = 6'h2A, port_oe = 6'h3F;
  cpu_req_t    req = '0;
  cpu_rsp_t    rsp;
  logic        kernel_mode, boot_jump, serial_boot, flash_en, flash_we, fcmd_accept, flash_irq;
  logic        flash_abort_en, flash_locked, spi_ss_n, spi_sclk, spi_mosi, tdo_oe;
  logic [31:0] boot_vector, flash_wdata, flash_rdata;
  logic [15:0] flash_addr;
  logic [5:0]  gpio_oe, gpio_out;
  int          mismatches = 0, total_checks = 0;
  memmap_ctrl uut (.mclk, .rst, .ext_reset_n, .test_reset_n, .req, .rsp, .kernel_mode, .boot_jump,
    .boot_vector, .serial_boot, .flash_en, .flash_we, .flash_addr, .flash_wdata, .flash_rdata, .fcmd_valid,
    .fcmd_accept, .fcmd_done, .flash_irq, .flash_abort_en, .flash_locked, .gpio_oe, .gpio_in,
    .gpio_out_reg(port_out), .gpio_oe_reg(port_oe), .spi_sel, .spi_miso, .gpio_out, .spi_ss_n, .spi_sclk,
    .spi_mosi, .tdo_oe);
  flash_model fm (.mclk, .en(flash_en), .we(flash_we), .addr(flash_addr), .wdata(flash_wdata),
    .rdata(flash_rdata));
  // 100 ns clock
  always #50 mclk = ~mclk;
  task automatic print_verdict;
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One request, held until the taking edge; the answer is read in its cycle
  task automatic acc(input logic w, input acc_size_t s, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk) req <= '{1'b1, w, s, a, d};
    @(posedge mclk) req.valid <= 1'b0;
    #1;
  endtask
  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] e);
    acc(1'b0, SZ_WORD, a, 32'h0);
    chk(n, e, rsp.ok ? rsp.rdata : 32'hDEAD_BEEF);
  endtask
  task automatic wr(input string n, input acc_size_t s, input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, s, a, d);
    chk(n, 32'h1, rsp.ok);
  endtask
  task automatic ab(input string n, input logic [31:0] a);
    acc(1'b0, SZ_WORD, a, 32'h0);
    chk(n, 32'h1, {rsp.abort, rsp.ok, rsp.rdata} == 34'h2_0000_0000);
  endtask
  task automatic boot_wait;
    int n = 0;
    while (boot_jump !== 1'b1 && n < 40) begin
      @(posedge mclk) #1 n++;
    end
    chk("boot vector", `RESET_VECTOR, boot_vector);
    chk("kernel span", `KERNEL_CYCLES, n);
  endtask
  task automatic t_boot;
    #1 chk("kernel at reset", 32'h1, kernel_mode);
    chk("pins as inputs", 32'h0, gpio_oe);
    chk("debug out off", 32'h0, tdo_oe);
    boot_wait;
    chk("serial boot", 32'h0, serial_boot);
    @(posedge mclk) #1 chk("kernel left", 32'h0, kernel_mode);
    chk("pins released", 32'h3F, gpio_oe);
  endtask
  task automatic t_regs;
    rd("remap reset", `MMR_REMAP_ADDR, 32'h0);
    rd("mode reset", `MMR_FMODE_ADDR, 32'h0);
    wr("mode low bits", SZ_WORD, `MMR_FMODE_ADDR, 32'h007F);
    rd("mode reserved", `MMR_FMODE_ADDR, 32'h007A);
    chk("lock on 11", 32'h0, flash_locked);
    chk("abort on", 32'h1, flash_abort_en);
    wr("mode lock", SZ_WORD, `MMR_FMODE_ADDR, 32'h0040);
    chk("lock on 10", 32'h1, flash_locked);
    chk("abort off", 32'h0, flash_abort_en);
  endtask
  task automatic t_sram;
    wr("sram word", SZ_WORD, `SRAM_BASE, 32'h4433_2211);
    wr("sram byte", SZ_BYTE, `SRAM_BASE + 2, 32'h0000_00EE);
    wr("sram half", SZ_HALF, `SRAM_BASE, 32'h0000_BEEF);
    rd("sram lanes", `SRAM_BASE, 32'h44EE_BEEF);
    wr("sram top", SZ_WORD, `SRAM_BASE + 32'hFFC, 32'h1234_5678);
    rd("sram top", `SRAM_BASE + 32'hFFC, 32'h1234_5678);
  endtask
  task automatic t_abort;
    ab("unmapped", 32'h2000_0000);
    ab("past sram", `SRAM_BASE + 32'h1000);
    ab("misaligned", `SRAM_BASE + 1);
    ab("kernel area", `FLASH_BASE + `FLASH_USER_LIMIT);
    rd("user flash top", `FLASH_BASE + 32'hF7FC, 32'hF1A5_3DFF);
    rd("register top", 32'hFFFF_F000, 32'h0);
  endtask
  task automatic t_remap;
    rd("flash at zero", 32'h0, 32'hF1A5_0000);
    rd("vector top", `VECTOR_TOP, 32'hF1A5_0008);
    wr("remap on", SZ_WORD, `MMR_REMAP_ADDR, 32'h1);
    rd("sram at zero", 32'h0, 32'h44EE_BEEF);
    ab("window past sram", 32'h0000_1000);
    wr("remap off", SZ_WORD, `MMR_REMAP_ADDR, 32'h0);
    rd("flash back", 32'h0, 32'hF1A5_0000);
  endtask
  task automatic pulse_done(input logic e);
    @(posedge mclk) fcmd_done <= 1'b1;
    @(posedge mclk) fcmd_done <= 1'b0;
    #1 chk("complete irq", e, flash_irq);
  endtask
  task automatic t_cmd;
    wr("mode clear", SZ_WORD, `MMR_FMODE_ADDR, 32'h0);
    wr("flash write off", SZ_WORD, `FLASH_BASE + 4, 32'hCAFE_0001);
    rd("flash kept", `FLASH_BASE + 4, 32'hF1A5_0001);
    @(posedge mclk) fcmd_valid <= 1'b1;
    #1 chk("accept off", 32'h0, fcmd_accept);
    wr("mode enable", SZ_WORD, `MMR_FMODE_ADDR, 32'h18);
    chk("accept on", 32'h1, fcmd_accept);
    @(posedge mclk) fcmd_valid <= 1'b0;
    wr("flash write on", SZ_WORD, `FLASH_BASE + 4, 32'hCAFE_0001);
    rd("flash changed", `FLASH_BASE + 4, 32'hCAFE_0001);
    pulse_done(1'b1);
    wr("irq off", SZ_WORD, `MMR_FMODE_ADDR, 32'h08);
    pulse_done(1'b0);
  endtask
  task automatic t_pins;
    @(posedge mclk) spi_sel <= 1'b1;
    gpio_in <= 6'h0A;
    spi_miso <= 1'b1;
    #1 chk("spi pins", 32'h69, {spi_ss_n, spi_sclk, spi_mosi, gpio_oe[3:0], gpio_out[2]});
    chk("pin outputs", 32'h2E, gpio_out);
  endtask
  // Mid-run pin reset with the boot-load strap set
  task automatic t_ext;
    wr("remap on", SZ_WORD, `MMR_REMAP_ADDR, 32'h1);
    @(posedge mclk) ext_reset_n <= 1'b0;
    test_reset_n <= 1'b1;
    #1 chk("pin reset", 32'h1, kernel_mode);
    chk("pins in reset", 32'h0, gpio_oe);
    @(posedge mclk) ext_reset_n <= 1'b1;
    boot_wait;
    chk("serial boot", 32'h1, serial_boot);
    rd("remap cleared", `MMR_REMAP_ADDR, 32'h0);
    rd("handler in flash", `RESET_VECTOR, 32'hF1A5_0000);
  endtask
  // Main sequence; reset held two cycles
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_boot;
    t_regs;
    t_sram;
    t_abort;
    t_remap;
    t_cmd;
    t_pins;
    t_ext;
    print_verdict;
  end
  // Watchdog far beyond the hundred or so cycles the run needs
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
endmodule // test_memory_map_remap_control
`default_nettype wire
